//--- flat_foc_consts.svh
// register offsets, field positions, reset values and timing figures of the flat and offset-compensation bank
`ifndef FLAT_FOC_CONSTS_SVH
`define FLAT_FOC_CONSTS_SVH

`define ADDR_FLAT_THRESHOLD 8'h67
`define ADDR_FLAT_HOLD_HYST 8'h68
`define ADDR_OFFSET_COMP 8'h69

`define THETA_LSB 0
`define THETA_MSB 5
`define HYST_LSB 0
`define HYST_MSB 2
`define HOLD_LSB 4
`define HOLD_MSB 5
`define FOC_Z_LSB 0
`define FOC_Y_LSB 2
`define FOC_X_LSB 4
`define FOC_GYRO_BIT 6

`define RST_THETA 6'h08
`define RST_HOLD 2'h1
`define RST_HYST 3'h1
`define RST_OFFSET_COMP 8'h00

`define FLAT_HOLD_UNIT_MS 640
`define CLK_FREQ_KHZ 100000

`endif

//--- flat_foc_pkg.sv
// types shared by the flat and offset-compensation bank
package flat_foc_pkg;

  typedef enum logic [1:0] {
    COMP_OFF = 2'b00,
    COMP_PLUS_1G = 2'b01,
    COMP_MINUS_1G = 2'b10,
    COMP_ZERO_G = 2'b11
  } comp_target_t;

  typedef enum logic {
    ST_STABLE = 1'b0,
    ST_TIMING = 1'b1
  } hold_state_t;

endpackage

//--- flat_hold_if.sv
// carrier between the register bank and the flat hold timer
interface flat_hold_if;
  logic [1:0] hold_code;
  logic flat_cond;
  logic flat_out;

  modport timer (input hold_code, input flat_cond, output flat_out);
  modport ctrl (output hold_code, output flat_cond, input flat_out);
endinterface

//--- flat_hold_timer.sv
// flat hold timer: releases the flat state only once it has been stable for the hold time
`include "flat_foc_consts.svh"

module flat_hold_timer
  import flat_foc_pkg::*;
#(
  parameter int unsigned HOLD_UNIT_CYCLES = `FLAT_HOLD_UNIT_MS * `CLK_FREQ_KHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bank side
  flat_hold_if.timer hif
);

  hold_state_t state;
  logic last_cond;
  logic [31:0] count;
  logic [31:0] limit;

  // code 0 means no hold, others are 1, 2, 4 units
  function automatic logic [31:0] hold_limit(input logic [1:0] code);
    case (code)
      2'h0: hold_limit = 32'h0;
      2'h1: hold_limit = HOLD_UNIT_CYCLES;
      2'h2: hold_limit = 32'(HOLD_UNIT_CYCLES * 2);
      default: hold_limit = 32'(HOLD_UNIT_CYCLES * 4);
    endcase
  endfunction

  assign limit = hold_limit(hif.hold_code);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_cond <= 1'b0;
    end else begin
      last_cond <= hif.flat_cond;
    end
  end

  // any change of the condition restarts the wait
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_STABLE;
      count <= 32'h0;
    end else if (hif.flat_cond != last_cond) begin
      state <= ST_TIMING;
      count <= 32'h0;
    end else begin
      case (state)
        ST_TIMING: begin
          if (count >= limit) begin
            state <= ST_STABLE;
          end else begin
            count <= count + 32'h1;
          end
        end
        ST_STABLE: begin
          count <= 32'h0;
        end
        default: begin
          state <= ST_STABLE;
        end
      endcase
    end
  end

  // shortening the hold code mid-wait takes effect at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hif.flat_out <= 1'b0;
    end else if (state == ST_TIMING && hif.flat_cond == last_cond && count >= limit) begin
      hif.flat_out <= last_cond;
    end
  end

endmodule

//--- flat_and_offset_comp_config.sv
// flat interrupt and fast offset compensation configuration bank
//
// Function
// - A six-bit flat threshold angle, 0 to about 44.8 degrees, sits in the low bits of byte 0x67.
// - The flat interrupt follows the flat condition only after it stayed unchanged for 0/640/1280/2560 ms.
// - A low-order hysteresis field in byte 0x68 is kept and handed to flat interrupt generation.
// - Byte 0x68 carries the hold time and hysteresis fields, its upper bits being reserved.
// - One enable bit turns on fast offset compensation for all three gyroscope axes.
// - Each accelerometer axis decodes a two-bit target: off, +1 g, -1 g or 0 g.
// - The offset compensation byte holds gyro and accel settings in bits 6:0, bit 7 always reads zero, resets to zero.
`include "flat_foc_consts.svh"

module flat_and_offset_comp_config
  import flat_foc_pkg::*;
#(
  parameter int unsigned HOLD_UNIT_CYCLES = `FLAT_HOLD_UNIT_MS * `CLK_FREQ_KHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial register port, already deserialised
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // flat detection
  input wire logic flat_cond,
  output logic [5:0] flat_threshold,
  output logic [2:0] level_hysteresis,
  output logic flat_int,
  // offset compensation engine, index 2 x, 1 y, 0 z
  output logic foc_gyro_en,
  output comp_target_t [2:0] foc_acc_target
);

  logic [1:0] flat_hold;
  logic [7:0] offset_comp_config;
  logic [7:0] next_rdata;
  flat_hold_if hif();

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
    hits = (addr == target);
  endfunction

  function automatic comp_target_t decode_target(input logic [1:0] code);
    case (code)
      2'b01: decode_target = COMP_PLUS_1G;
      2'b10: decode_target = COMP_MINUS_1G;
      2'b11: decode_target = COMP_ZERO_G;
      default: decode_target = COMP_OFF;
    endcase
  endfunction

  // only the defined fields are stored, so reserved bits cannot leak into behaviour
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flat_threshold <= `RST_THETA;
    end else if (reg_wr && hits(reg_addr, `ADDR_FLAT_THRESHOLD)) begin
      flat_threshold <= reg_wdata[`THETA_MSB:`THETA_LSB];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flat_hold <= `RST_HOLD;
      level_hysteresis <= `RST_HYST;
    end else if (reg_wr && hits(reg_addr, `ADDR_FLAT_HOLD_HYST)) begin
      flat_hold <= reg_wdata[`HOLD_MSB:`HOLD_LSB];
      level_hysteresis <= reg_wdata[`HYST_MSB:`HYST_LSB];
    end
  end

  // bit 7 is reserved; the other seven are stored as they come
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      offset_comp_config <= `RST_OFFSET_COMP;
    end else if (reg_wr && hits(reg_addr, `ADDR_OFFSET_COMP)) begin
      offset_comp_config <= {1'b0, reg_wdata[6:0]};
    end
  end

  // decoded outputs lag the stored byte by one cycle so they leave from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      foc_gyro_en <= 1'b0;
    end else begin
      foc_gyro_en <= offset_comp_config[`FOC_GYRO_BIT];
    end
  end

  generate
    for (genvar a = 0; a < 3; a++) begin : g_axis
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          foc_acc_target[a] <= COMP_OFF;
        end else begin
          foc_acc_target[a] <= decode_target(offset_comp_config[2*a +: 2]);
        end
      end
    end
  endgenerate

  // unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (hits(reg_addr, `ADDR_FLAT_THRESHOLD)) begin
      next_rdata = {2'h0, flat_threshold};
    end else if (hits(reg_addr, `ADDR_FLAT_HOLD_HYST)) begin
      next_rdata = {2'h0, flat_hold, 1'b0, level_hysteresis};
    end else if (hits(reg_addr, `ADDR_OFFSET_COMP)) begin
      next_rdata = offset_comp_config;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  assign hif.hold_code = flat_hold;
  assign hif.flat_cond = flat_cond;
  assign flat_int = hif.flat_out;

  flat_hold_timer #(
    .HOLD_UNIT_CYCLES(HOLD_UNIT_CYCLES)
  ) u_hold (
    .ref_clk(ref_clk),
    .rst(rst),
    .hif(hif.timer)
  );

endmodule

//--- flat_foc_asserts.sv
// port assertions for the flat and offset-compensation bank
module flat_foc_asserts
  import flat_foc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // flat condition and configuration outputs
  input wire logic flat_cond,
  input wire logic [5:0] flat_threshold,
  input wire logic [2:0] level_hysteresis,
  input wire logic flat_int,
  input wire logic foc_gyro_en,
  input wire comp_target_t [2:0] foc_acc_target
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_answered: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_once: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  a_theta_stored: assert property (reg_wr && reg_addr == 8'h67
    |=> flat_threshold == $past(reg_wdata[5:0])) else $error("threshold not stored");
  a_hyst_stored: assert property (reg_wr && reg_addr == 8'h68
    |=> level_hysteresis == $past(reg_wdata[2:0])) else $error("hysteresis not stored");
  a_hold_byte_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h68
    |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3] && reg_rdata[2:0] == level_hysteresis)
    else $error("hold byte read wrong");
  a_comp_decoded: assert property (reg_wr && reg_addr == 8'h69
    |=> ##1 foc_gyro_en == $past(reg_wdata[6], 2) && foc_acc_target[2] == $past(reg_wdata[5:4], 2))
    else $error("comp byte not decoded");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h67 || reg_addr > 8'h69)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_flat_settled: assert property ($changed(flat_int)
    |-> flat_int == $past(flat_cond) && flat_int == $past(flat_cond, 2))
    else $error("flat output moved on unstable input");
endmodule

bind flat_and_offset_comp_config flat_foc_asserts flat_foc_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .flat_cond(flat_cond), .flat_threshold(flat_threshold),
  .level_hysteresis(level_hysteresis), .flat_int(flat_int),
  .foc_gyro_en(foc_gyro_en), .foc_acc_target(foc_acc_target));

//--- flat_foc_host.sv
// host model that drives the register port
module flat_foc_host (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    // released data is scrambled so nothing relies on a stale byte
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    // answer stands one cycle only, so it is taken just after the taking edge
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule

//--- tb_flat_and_offset_comp_config.sv
// self-checking bench for the flat and offset-compensation bank
module tb_flat_and_offset_comp_config
  import flat_foc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned UNIT = 8;
  logic ref_clk, rst, flat_cond, reg_wr, reg_rd, reg_rvalid, flat_int, foc_gyro_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [5:0] flat_threshold;
  logic [2:0] level_hysteresis;
  comp_target_t [2:0] foc_acc_target;
  int n_mismatch = 0;
  int tests_run = 0;
  int lim;
  flat_and_offset_comp_config #(.HOLD_UNIT_CYCLES(UNIT)) flat_and_offset_comp_config_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .flat_cond(flat_cond), .flat_threshold(flat_threshold),
    .level_hysteresis(level_hysteresis), .flat_int(flat_int),
    .foc_gyro_en(foc_gyro_en), .foc_acc_target(foc_acc_target));
  flat_foc_host flat_foc_host_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    flat_foc_host_inst.rd(a, rv);
    chk("rdata", e, rv);
  endtask
  task automatic w(logic [7:0] a, logic [7:0] d);
    flat_foc_host_inst.wr(a, d);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // whole run is well under 1500 cycles
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    flat_cond = 1'b0;
    cyc(12);
    rst = 1'b0;
    rchk(8'h67, 8'h08);
    rchk(8'h68, 8'h11);
    rchk(8'h69, 8'h00);
    $display("test reset values done");
    w(8'h67, 8'hFF);
    chk("threshold", 8'h3F, {2'h0, flat_threshold});
    rchk(8'h67, 8'h3F);
    w(8'h68, 8'hFF);
    chk("hysteresis", 8'h07, {5'h00, level_hysteresis});
    rchk(8'h68, 8'h37);
    w(8'h6A, 8'hFF);
    rchk(8'h6A, 8'h00);
    $display("test field widths done");
    for (int c = 0; c < 4; c++) begin
      w(8'h69, {1'b1, c[0], {3{c[1:0]}}});
      cyc(1);
      chk("gyro", {7'h00, c[0]}, {7'h00, foc_gyro_en});
      chk("targets", {2'h0, {3{c[1:0]}}}, {2'h0, foc_acc_target});
      rchk(8'h69, {1'b0, c[0], {3{c[1:0]}}});
    end
    // distinct codes per axis so a swapped axis shows
    w(8'h69, 8'h1B);
    cyc(1);
    chk("gyro", 8'h00, {7'h00, foc_gyro_en});
    chk("targets", 8'h1B, {2'h0, foc_acc_target});
    $display("test offset comp done");
    for (int h = 0; h < 4; h++) begin
      lim = (h == 0) ? 0 : UNIT << (h - 1);
      w(8'h68, {2'h0, h[1:0], 4'h0});
      if (h > 0) begin
        flat_cond = 1'b1;
        cyc(3);
        chk("flat_int", 8'h00, {7'h00, flat_int});
        flat_cond = 1'b0;
        cyc(lim + 6);
        chk("flat_int", 8'h00, {7'h00, flat_int});
      end
      flat_cond = 1'b1;
      cyc(lim);
      chk("flat_int", 8'h00, {7'h00, flat_int});
      cyc(6);
      chk("flat_int", 8'h01, {7'h00, flat_int});
      flat_cond = 1'b0;
      cyc(lim);
      chk("flat_int", 8'h01, {7'h00, flat_int});
      cyc(6);
      chk("flat_int", 8'h00, {7'h00, flat_int});
    end
    $display("test flat hold done");
    end_sim();
  end
endmodule
